// File: src/uvfmc_pkg.sv
package uvfmc_pkg;
	// register byte addresses
	localparam logic [15:0] UVFMC_ADDR_UVID_LO  = 16'h0328;
	localparam logic [15:0] UVFMC_ADDR_UVID_HI  = 16'h032b;
	localparam logic [15:0] UVFMC_ADDR_MAC0     = 16'h0330;
	localparam logic [15:0] UVFMC_ADDR_MAC1     = 16'h0331;
	// unknown vid control fields (32-bit register, four bytes)
	localparam int          UVFMC_UVID_EN_BIT   = 31;
	localparam int          UVFMC_UVID_HI_LSB   = 24;
	localparam int          UVFMC_PORTS         = 7;
	localparam logic [6:0]  UVFMC_UVID_MASK_RST = 7'h00;
	localparam logic        UVFMC_UVID_EN_RST   = 1'b0;
	// mac control 0 fields
	localparam int          UVFMC_MAC0_ALT_BIT  = 7;
	localparam int          UVFMC_MAC0_LEN_BIT  = 3;
	localparam int          UVFMC_MAC0_FCD_BIT  = 1;
	localparam int          UVFMC_MAC0_AGG_BIT  = 0;
	localparam logic [7:0]  UVFMC_MAC0_RST      = 8'h04;
	// mac control 1: only the no-excessive-collision-drop bit is kept here
	localparam int          UVFMC_MAC1_NECD_BIT = 3;
	localparam logic        UVFMC_MAC1_NECD_RST = 1'b0;
	// frame constants
	localparam logic [15:0] UVFMC_LEN_LIMIT     = 16'h05dc;
	localparam logic [15:0] UVFMC_ETYPE_PAUSE   = 16'h8808;
	localparam logic [47:0] UVFMC_DA_PAUSE      = 48'h0180c2000001;
	localparam logic [4:0]  UVFMC_COLL_LIMIT    = 5'h10;
	// forwarding class of a frame
	typedef enum logic [1:0] {
		UVFMC_CLS_NONE = 2'b00,
		UVFMC_CLS_UVID = 2'b01,
		UVFMC_CLS_UUC  = 2'b10,
		UVFMC_CLS_UMC  = 2'b11
	} uvfmc_cls_t;
endpackage

// File: src/uvfmc_regs.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
// Function
// - enable set: unknown-VID frames go to ports picked by the mask
// - enable clear (reset value): no mask forwarding for unknown-VID frames
// - mask one forwards to that port, zero blocks it
// - alternate back-off acts only on half-duplex ports
// - length check only for length field below 1500
// - length check on: drop frames whose real length mismatches field
// - drop mode set: drop if pause ethertype or pause address
// - drop mode clear: drop only if pause ethertype and pause address
// - aggressive back-off only on half-duplex ports when bit 0 set
// - no-excessive-collision-drop keeps frames after 16 collisions
// - unknown VID beats unknown unicast, which beats unknown multicast
module uvfmc_regs
	import uvfmc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// received frame classification, one cycle pulse per frame
	input  wire logic        rx_valid,
	input  wire logic        rx_unknown_vid,
	input  wire logic        rx_unknown_uc,
	input  wire logic        rx_unknown_mc,
	input  wire logic [6:0]  rx_uc_ports,
	input  wire logic [6:0]  rx_mc_ports,
	input  wire logic [15:0] rx_type_len,
	input  wire logic [15:0] rx_actual_len,
	input  wire logic [47:0] rx_da,
	// transmit collision status
	input  wire logic        tx_done,
	input  wire logic [4:0]  tx_collisions,
	input  wire logic [6:0]  port_half_duplex,
	// decisions
	output logic             fwd_valid,
	output logic      [6:0]  fwd_ports,
	output logic             fwd_drop,
	output logic      [1:0]  fwd_class,
	output logic             tx_coll_drop,
	output logic      [6:0]  alt_backoff_en,
	output logic      [6:0]  agg_backoff_en
);
	typedef struct packed {
		logic       uvid_en;
		logic [6:0] uvid_mask;
		logic [7:0] mac0;
		logic       necd;
		logic [7:0] rdata;
		logic       fwd_valid;
		logic [6:0] fwd_ports;
		logic       fwd_drop;
		logic [1:0] fwd_class;
		logic       coll_drop;
		logic [6:0] alt_en;
		logic [6:0] agg_en;
	} uvfmc_state_t;

	uvfmc_state_t st_q;
	uvfmc_state_t st_d;

	function automatic logic uvfmc_hit(input logic [15:0] a, input logic [15:0] b);
		return a == b;
	endfunction

	function automatic logic [7:0] uvfmc_read(input logic [15:0] a, input uvfmc_state_t s);
		logic [7:0] v;
		v = 8'h00;
		// little-endian bytes; bits 30:7 stay zero
		if (uvfmc_hit(a, UVFMC_ADDR_UVID_LO))
			v = {1'b0, s.uvid_mask};
		else if (uvfmc_hit(a, UVFMC_ADDR_UVID_HI))
			v = {s.uvid_en, 7'h00};
		else if (uvfmc_hit(a, UVFMC_ADDR_MAC0))
			v = s.mac0;
		else if (uvfmc_hit(a, UVFMC_ADDR_MAC1))
			v = {4'h0, s.necd, 3'h0};
		return v;
	endfunction

	logic       len_bad;
	logic       da_pause;
	logic       et_pause;
	logic       fc_drop;

	always_comb
	begin
		st_d = st_q;
		len_bad  = 1'b0;
		da_pause = 1'b0;
		et_pause = 1'b0;
		fc_drop  = 1'b0;
		// register writes; unmapped addresses are ignored and read zero
		if (reg_wr)
		begin
			if (uvfmc_hit(reg_addr, UVFMC_ADDR_UVID_LO))
				st_d.uvid_mask = reg_wdata[UVFMC_PORTS-1:0];
			if (uvfmc_hit(reg_addr, UVFMC_ADDR_UVID_HI))
				st_d.uvid_en = reg_wdata[UVFMC_UVID_EN_BIT-UVFMC_UVID_HI_LSB];
			if (uvfmc_hit(reg_addr, UVFMC_ADDR_MAC0))
				st_d.mac0 = reg_wdata;
			if (uvfmc_hit(reg_addr, UVFMC_ADDR_MAC1))
				st_d.necd = reg_wdata[UVFMC_MAC1_NECD_BIT];
		end
		st_d.rdata = reg_rd ? uvfmc_read(reg_addr, st_q) : 8'h00;

		// back-off enables gated per half-duplex port
		st_d.alt_en = port_half_duplex & {UVFMC_PORTS{st_q.mac0[UVFMC_MAC0_ALT_BIT]}};
		st_d.agg_en = port_half_duplex & {UVFMC_PORTS{st_q.mac0[UVFMC_MAC0_AGG_BIT]}};

		// excessive collisions: drop unless the keep option is set
		st_d.coll_drop = tx_done && (tx_collisions >= UVFMC_COLL_LIMIT)
			&& !st_q.necd;

		// frame filtering
		len_bad = st_q.mac0[UVFMC_MAC0_LEN_BIT]
			&& (rx_type_len < UVFMC_LEN_LIMIT)
			&& (rx_actual_len != rx_type_len);
		et_pause = rx_type_len == UVFMC_ETYPE_PAUSE;
		da_pause = rx_da == UVFMC_DA_PAUSE;
		fc_drop = st_q.mac0[UVFMC_MAC0_FCD_BIT] ? (et_pause || da_pause)
			: (et_pause && da_pause);

		st_d.fwd_valid = rx_valid;
		st_d.fwd_drop  = rx_valid && (len_bad || fc_drop);
		st_d.fwd_ports = 7'h00;
		st_d.fwd_class = UVFMC_CLS_NONE;
		if (rx_valid)
		begin
			// unknown vid first, then unicast, then multicast
			if (rx_unknown_vid)
			begin
				st_d.fwd_class = UVFMC_CLS_UVID;
				// disabled: no mask-based forwarding, no ports
				st_d.fwd_ports = st_q.uvid_en ? st_q.uvid_mask : 7'h00;
			end
			else if (rx_unknown_uc)
			begin
				st_d.fwd_class = UVFMC_CLS_UUC;
				st_d.fwd_ports = rx_uc_ports;
			end
			else if (rx_unknown_mc)
			begin
				st_d.fwd_class = UVFMC_CLS_UMC;
				st_d.fwd_ports = rx_mc_ports;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q           <= '0;
			st_q.uvid_en   <= UVFMC_UVID_EN_RST;
			st_q.uvid_mask <= UVFMC_UVID_MASK_RST;
			st_q.mac0      <= UVFMC_MAC0_RST;
			st_q.necd      <= UVFMC_MAC1_NECD_RST;
		end
		else
			st_q <= st_d;
	end

	assign reg_rdata      = st_q.rdata;
	assign fwd_valid      = st_q.fwd_valid;
	assign fwd_ports      = st_q.fwd_ports;
	assign fwd_drop       = st_q.fwd_drop;
	assign fwd_class      = st_q.fwd_class;
	assign tx_coll_drop   = st_q.coll_drop;
	assign alt_backoff_en = st_q.alt_en;
	assign agg_backoff_en = st_q.agg_en;

	// register port: storage, read-back and idle level of the read data
	a_mask_bit_map: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && reg_addr == UVFMC_ADDR_UVID_LO
		|=> st_q.uvid_mask == $past(reg_wdata[UVFMC_PORTS-1:0])) else $error("mask write lost");

	a_mask_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!(reg_wr && reg_addr == UVFMC_ADDR_UVID_LO)
		|=> $stable(st_q.uvid_mask)) else $error("mask changed without write");

	a_mask_read: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == UVFMC_ADDR_UVID_LO
		|=> reg_rdata[UVFMC_PORTS-1:0] == $past(st_q.uvid_mask)) else $error("mask read wrong");

	a_en_write: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && reg_addr == UVFMC_ADDR_UVID_HI
		|=> st_q.uvid_en == $past(reg_wdata[UVFMC_UVID_EN_BIT-UVFMC_UVID_HI_LSB]))
		else $error("enable write lost");

	a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == UVFMC_ADDR_UVID_LO
		|=> !reg_rdata[UVFMC_PORTS]) else $error("reserved bit nonzero");

	a_rsvd_hi_zero: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == UVFMC_ADDR_UVID_HI
		|=> reg_rdata[UVFMC_PORTS-1:0] == 7'h00) else $error("reserved high bits nonzero");

	a_rsvd_mid_zero: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr > UVFMC_ADDR_UVID_LO && reg_addr < UVFMC_ADDR_UVID_HI
		|=> reg_rdata == 8'h00) else $error("reserved middle bytes nonzero");

	a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 8'h00) else $error("read data without strobe");

	a_mac0_write: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && reg_addr == UVFMC_ADDR_MAC0
		|=> st_q.mac0 == $past(reg_wdata)) else $error("mac control write lost");

	a_necd_write: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && reg_addr == UVFMC_ADDR_MAC1
		|=> st_q.necd == $past(reg_wdata[UVFMC_MAC1_NECD_BIT])) else $error("keep bit lost");

	// frame path: port choice and precedence
	a_uvid_fwd_mask: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && rx_unknown_vid && st_q.uvid_en && !reg_wr
		|=> fwd_ports == $past(st_q.uvid_mask)) else $error("mask not used");

	a_uvid_fwd_off: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && rx_unknown_vid && !st_q.uvid_en
		|=> fwd_ports == 7'h00) else $error("disabled forward leaked");

	a_mask_flood: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && rx_unknown_vid && st_q.uvid_en && st_q.uvid_mask == {UVFMC_PORTS{1'b1}}
		|=> fwd_ports == {UVFMC_PORTS{1'b1}}) else $error("flood mask not applied");

	a_mask_none: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && rx_unknown_vid && st_q.uvid_mask == 7'h00
		|=> fwd_ports == 7'h00) else $error("empty mask forwarded");

	a_prio_uvid: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && rx_unknown_vid |=> fwd_class == UVFMC_CLS_UVID)
		else $error("vid precedence broken");

	a_prio_uc: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && !rx_unknown_vid && rx_unknown_uc && rx_unknown_mc
		|=> fwd_class == UVFMC_CLS_UUC) else $error("unicast precedence broken");

	a_uc_ports: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && !rx_unknown_vid && rx_unknown_uc
		|=> fwd_ports == $past(rx_uc_ports)) else $error("unicast ports wrong");

	a_prio_mc: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && !rx_unknown_vid && !rx_unknown_uc && rx_unknown_mc
		|=> fwd_class == UVFMC_CLS_UMC && fwd_ports == $past(rx_mc_ports))
		else $error("multicast handling wrong");

	a_class_none: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && !rx_unknown_vid && !rx_unknown_uc && !rx_unknown_mc
		|=> fwd_class == UVFMC_CLS_NONE && fwd_ports == 7'h00) else $error("known frame classed");

	a_fwd_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid |=> fwd_valid) else $error("decision missing");

	a_fwd_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!rx_valid |=> !fwd_valid && !fwd_drop && fwd_ports == 7'h00
		&& fwd_class == UVFMC_CLS_NONE) else $error("decision without frame");

	// frame path: length check and flow-control drops
	a_len_skip: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && rx_type_len >= UVFMC_LEN_LIMIT && rx_type_len != UVFMC_ETYPE_PAUSE
		&& rx_da != UVFMC_DA_PAUSE |=> !fwd_drop) else $error("long frame dropped");

	a_len_drop: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && st_q.mac0[UVFMC_MAC0_LEN_BIT] && rx_type_len < UVFMC_LEN_LIMIT
		&& rx_actual_len != rx_type_len |=> fwd_drop) else $error("bad length kept");

	a_len_off: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && !st_q.mac0[UVFMC_MAC0_LEN_BIT] && rx_type_len != UVFMC_ETYPE_PAUSE
		&& rx_da != UVFMC_DA_PAUSE |=> !fwd_drop) else $error("length checked while off");

	a_len_match: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && rx_actual_len == rx_type_len && rx_type_len != UVFMC_ETYPE_PAUSE
		&& rx_da != UVFMC_DA_PAUSE |=> !fwd_drop) else $error("good length dropped");

	a_fc_or: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && st_q.mac0[UVFMC_MAC0_FCD_BIT] && rx_da == UVFMC_DA_PAUSE
		|=> fwd_drop) else $error("pause da not dropped");

	a_fc_or_et: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && st_q.mac0[UVFMC_MAC0_FCD_BIT] && rx_type_len == UVFMC_ETYPE_PAUSE
		|=> fwd_drop) else $error("pause type not dropped");

	a_fc_and: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && !st_q.mac0[UVFMC_MAC0_FCD_BIT] && !st_q.mac0[UVFMC_MAC0_LEN_BIT]
		&& rx_da == UVFMC_DA_PAUSE && rx_type_len != UVFMC_ETYPE_PAUSE
		|=> !fwd_drop) else $error("and mode dropped");

	a_fc_and_et: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && !st_q.mac0[UVFMC_MAC0_FCD_BIT] && rx_type_len == UVFMC_ETYPE_PAUSE
		&& rx_da != UVFMC_DA_PAUSE |=> !fwd_drop) else $error("and mode dropped type");

	a_fc_and_both: assert property (@(posedge clk) disable iff (!rst_n)
		rx_valid && rx_type_len == UVFMC_ETYPE_PAUSE && rx_da == UVFMC_DA_PAUSE
		|=> fwd_drop) else $error("full pause frame kept");

	// back-off enables per half-duplex port
	a_full_dup_alt: assert property (@(posedge clk) disable iff (!rst_n)
		!port_half_duplex[0] |=> !alt_backoff_en[0] && !agg_backoff_en[0])
		else $error("backoff in full duplex");

	a_alt_enable: assert property (@(posedge clk) disable iff (!rst_n)
		port_half_duplex[0] && st_q.mac0[UVFMC_MAC0_ALT_BIT] |=> alt_backoff_en[0])
		else $error("alternate backoff missing");

	a_alt_off: assert property (@(posedge clk) disable iff (!rst_n)
		!st_q.mac0[UVFMC_MAC0_ALT_BIT] |=> alt_backoff_en == 7'h00)
		else $error("alternate backoff while off");

	a_agg_enable: assert property (@(posedge clk) disable iff (!rst_n)
		port_half_duplex[0] && st_q.mac0[UVFMC_MAC0_AGG_BIT] |=> agg_backoff_en[0])
		else $error("aggressive backoff missing");

	a_agg_off: assert property (@(posedge clk) disable iff (!rst_n)
		!st_q.mac0[UVFMC_MAC0_AGG_BIT] |=> agg_backoff_en == 7'h00)
		else $error("aggressive backoff while off");

	// excessive collisions
	a_coll_keep: assert property (@(posedge clk) disable iff (!rst_n)
		tx_done && tx_collisions >= UVFMC_COLL_LIMIT |=> tx_coll_drop == !$past(st_q.necd))
		else $error("collision drop wrong");

	a_coll_low: assert property (@(posedge clk) disable iff (!rst_n)
		tx_done && tx_collisions < UVFMC_COLL_LIMIT |=> !tx_coll_drop)
		else $error("drop below collision limit");

	a_coll_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!tx_done |=> !tx_coll_drop) else $error("drop without attempt");

	// main scenarios reached
	c_uvid_fwd: cover property (@(posedge clk) rx_valid && rx_unknown_vid && st_q.uvid_en);
	c_fc_drop: cover property (@(posedge clk) rx_valid && fc_drop);
	c_len_drop: cover property (@(posedge clk) rx_valid && len_bad);
	c_coll_keep: cover property (@(posedge clk) tx_done && tx_collisions >= UVFMC_COLL_LIMIT
		&& st_q.necd);
	c_prio_vid_uc: cover property (@(posedge clk) rx_valid && rx_unknown_vid && rx_unknown_uc);
endmodule

// File: tb/uvfmc_regs_tb.sv
`timescale 1ns/1ns
module uvfmc_regs_tb
	import uvfmc_pkg::*;
;
	logic        clk, rst_n, reg_wr, reg_rd, rx_valid, tx_done;
	logic        rx_unknown_vid, rx_unknown_uc, rx_unknown_mc;
	logic [15:0] reg_addr, rx_type_len, rx_actual_len;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [6:0]  rx_uc_ports, rx_mc_ports, port_half_duplex, fwd_ports;
	logic [6:0]  alt_backoff_en, agg_backoff_en;
	logic [47:0] rx_da;
	logic [4:0]  tx_collisions;
	logic        fwd_valid, fwd_drop, tx_coll_drop;
	logic [1:0]  fwd_class;
	int          miscompares, cmp_count;

	uvfmc_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
		.rx_unknown_vid(rx_unknown_vid), .rx_unknown_uc(rx_unknown_uc),
		.rx_unknown_mc(rx_unknown_mc), .rx_uc_ports(rx_uc_ports), .rx_mc_ports(rx_mc_ports),
		.rx_type_len(rx_type_len), .rx_actual_len(rx_actual_len), .rx_da(rx_da),
		.tx_done(tx_done), .tx_collisions(tx_collisions), .port_half_duplex(port_half_duplex),
		.fwd_valid(fwd_valid), .fwd_ports(fwd_ports), .fwd_drop(fwd_drop),
		.fwd_class(fwd_class), .tx_coll_drop(tx_coll_drop), .alt_backoff_en(alt_backoff_en),
		.agg_backoff_en(agg_backoff_en));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, exp});
		@(posedge clk);
		#1 chk({8'h00, reg_rdata}, 16'h0000);
	endtask

	// expected word is {valid, ports, drop, class}
	task automatic frame(input logic [2:0] unk, input logic [15:0] tl, input logic [15:0] al,
		input logic [47:0] da, input logic [10:0] exp);
		@(posedge clk);
		rx_valid <= 1'b1;
		{rx_unknown_vid, rx_unknown_uc, rx_unknown_mc} <= unk;
		rx_type_len <= tl;
		rx_actual_len <= al;
		rx_da <= da;
		@(posedge clk);
		rx_valid <= 1'b0;
		#1 chk({5'h00, fwd_valid, fwd_ports, fwd_drop, fwd_class}, {5'h00, exp});
		@(posedge clk);
		#1 chk({5'h00, fwd_valid, fwd_ports, fwd_drop, fwd_class}, 16'h0000);
	endtask

	task automatic coll(input logic [4:0] n, input logic exp);
		@(posedge clk);
		tx_done <= 1'b1;
		tx_collisions <= n;
		@(posedge clk);
		tx_done <= 1'b0;
		#1 chk({15'h0000, tx_coll_drop}, {15'h0000, exp});
	endtask

	task automatic give_verdict();
		if (miscompares == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		{miscompares, cmp_count} = '0;
		{rst_n, reg_wr, reg_rd, rx_valid, tx_done} = '0;
		{rx_unknown_vid, rx_unknown_uc, rx_unknown_mc, tx_collisions} = '0;
		{reg_addr, reg_wdata, rx_type_len, rx_actual_len, rx_da} = '0;
		rx_uc_ports = 7'h12;
		rx_mc_ports = 7'h21;
		port_half_duplex = 7'h00;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(16'h0328, 8'h00);
		rd(16'h032b, 8'h00);
		rd(16'h0330, 8'h04);
		rd(16'h0331, 8'h00);
		rd(16'h032c, 8'h00);
		wr(16'h0328, 8'hff);
		wr(16'h0329, 8'hff);
		wr(16'h032b, 8'hff);
		rd(16'h0328, 8'h7f);
		rd(16'h0329, 8'h00);
		rd(16'h032b, 8'h80);
		frame(3'b100, 16'h0600, 16'h0600, 48'h0, {1'b1, 7'h7f, 1'b0, 2'd1});
		wr(16'h0328, 8'h05);
		frame(3'b111, 16'h0600, 16'h0600, 48'h0, {1'b1, 7'h05, 1'b0, 2'd1});
		frame(3'b011, 16'h0600, 16'h0600, 48'h0, {1'b1, 7'h12, 1'b0, 2'd2});
		frame(3'b001, 16'h0600, 16'h0600, 48'h0, {1'b1, 7'h21, 1'b0, 2'd3});
		wr(16'h0328, 8'h00);
		frame(3'b100, 16'h0600, 16'h0600, 48'h0, {1'b1, 7'h00, 1'b0, 2'd1});
		wr(16'h032b, 8'h00);
		wr(16'h0328, 8'h7f);
		frame(3'b100, 16'h0600, 16'h0600, 48'h0, {1'b1, 7'h00, 1'b0, 2'd1});
		wr(16'h032b, 8'h80);
		frame(3'b100, 16'h0064, 16'h0065, 48'h0, {1'b1, 7'h7f, 1'b0, 2'd1});
		wr(16'h0330, 8'h08);
		rd(16'h0330, 8'h08);
		frame(3'b100, 16'h0064, 16'h0065, 48'h0, {1'b1, 7'h7f, 1'b1, 2'd1});
		frame(3'b100, 16'h0064, 16'h0064, 48'h0, {1'b1, 7'h7f, 1'b0, 2'd1});
		frame(3'b100, 16'h05dc, 16'h0001, 48'h0, {1'b1, 7'h7f, 1'b0, 2'd1});
		frame(3'b100, 16'h05db, 16'h0001, 48'h0, {1'b1, 7'h7f, 1'b1, 2'd1});
		frame(3'b100, 16'h8808, 16'h0040, 48'h0, {1'b1, 7'h7f, 1'b0, 2'd1});
		frame(3'b100, 16'h0600, 16'h0600, UVFMC_DA_PAUSE, {1'b1, 7'h7f, 1'b0, 2'd1});
		frame(3'b100, 16'h8808, 16'h0040, UVFMC_DA_PAUSE, {1'b1, 7'h7f, 1'b1, 2'd1});
		wr(16'h0330, 8'h02);
		frame(3'b100, 16'h8808, 16'h0040, 48'h0, {1'b1, 7'h7f, 1'b1, 2'd1});
		frame(3'b100, 16'h0600, 16'h0600, UVFMC_DA_PAUSE, {1'b1, 7'h7f, 1'b1, 2'd1});
		frame(3'b100, 16'h0600, 16'h0600, 48'h0, {1'b1, 7'h7f, 1'b0, 2'd1});
		// backoff outputs follow duplex levels with one cycle of latency
		port_half_duplex <= 7'h55;
		wr(16'h0330, 8'h80);
		@(posedge clk);
		#1 chk({alt_backoff_en, agg_backoff_en}, {7'h55, 7'h00});
		wr(16'h0330, 8'h01);
		@(posedge clk);
		#1 chk({alt_backoff_en, agg_backoff_en}, {7'h00, 7'h55});
		coll(5'h10, 1'b1);
		coll(5'h0f, 1'b0);
		wr(16'h0330, 8'h80);
		wr(16'h0331, 8'hff);
		rd(16'h0331, 8'h08);
		coll(5'h1f, 1'b0);
		// second reset in mid-run brings back the reset values
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rd(16'h0330, 8'h04);
		rd(16'h032b, 8'h00);
		rd(16'h0331, 8'h00);
		give_verdict();
	end
endmodule
